/* cmd_decoder_map.svh */
`ifndef CMD_DECODER_MAP_SVH
`define CMD_DECODER_MAP_SVH
`define CMD_REG_ADDR        8'h7E
`define CMD_REG_RESET       8'h00
`define CMD_READ_VALUE      8'h00
`define CMD_SOFT_RESET      8'hB6
`define CMD_NVM_FIRST       8'h5D
`define CMD_NVM_READ        8'hA5
`define CMD_NVM_PROG        8'hA0
`endif

/* cmd_decoder_pkg.sv */
`default_nettype none
package cmd_decoder_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED} seq_e;
	typedef struct packed {
		seq_e  seq;
		logic  softReset;
		logic  nvmReadEn;
		logic  nvmProgEn;
		logic  ackSuppress;
		byte_t readData;
	} state_s;
endpackage
`default_nettype wire

/* sensor_command_register_decoder.sv */
// Notes on behaviour
// - Command register always reads back zero.
// - Code B6 resets all user configuration.
// - Soft reset over I2C gets no acknowledge.
// - Code 5D arms memory access sequence.
// - 5D then A5 enables memory read.
// - 5D then A0 enables memory programming.
// - Wrong command mid-sequence returns to idle.
`include "cmd_decoder_map.svh"
`default_nettype none
module sensor_command_register_decoder (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   regWrite,
	input  wire logic                   regRead,
	input  wire logic                   busIsI2c,
	input  wire logic [7:0]             regAddr,
	input  wire cmd_decoder_pkg::byte_t regWdata,
	output var  cmd_decoder_pkg::byte_t regRdata,
	output var  logic                   ackSuppress,
	output var  logic                   softReset,
	output var  logic                   nvmReadEn,
	output var  logic                   nvmProgEn
);
	import cmd_decoder_pkg::*;

	state_s stateReg;
	state_s stateNext;
	logic   cmdWrite;

	// ---------------------------------------------------------------
	// Decode helpers
	// ---------------------------------------------------------------
	// One command write of a given code; shared by several of the checks below
	function automatic logic cmdIs(input logic wrStrobe, input byte_t data, input byte_t code);
		return wrStrobe && (data == code);
	endfunction

	// The two codes that only mean something right after the arming code
	function automatic logic isClosingCode(input byte_t data);
		return (data == `CMD_NVM_READ) || (data == `CMD_NVM_PROG);
	endfunction

	// Every code that the decoder gives a meaning to
	function automatic logic isDefinedCode(input byte_t data);
		return (data == `CMD_SOFT_RESET) || (data == `CMD_NVM_FIRST) || isClosingCode(data);
	endfunction

	// ---------------------------------------------------------------
	// Command decode
	// ---------------------------------------------------------------
	// Write strobe comes from the serial slave on this same clock
	assign cmdWrite = regWrite && (regAddr == `CMD_REG_ADDR);

	// Next state; enables are pulses so the memory engine sees one event per command
	always_comb begin
		stateNext             = stateReg;
		stateNext.softReset   = 1'b0;
		stateNext.nvmReadEn   = 1'b0;
		stateNext.nvmProgEn   = 1'b0;
		stateNext.ackSuppress = 1'b0;
		stateNext.readData    = `CMD_READ_VALUE;
		if (cmdWrite) begin
			stateNext.seq = SEQ_IDLE;
			unique case (regWdata)
				`CMD_SOFT_RESET: begin
					stateNext.softReset   = 1'b1;
					stateNext.ackSuppress = busIsI2c;
				end
				`CMD_NVM_FIRST: begin
					stateNext.seq = SEQ_ARMED;
				end
				`CMD_NVM_READ: begin
					stateNext.nvmReadEn = (stateReg.seq == SEQ_ARMED);
				end
				`CMD_NVM_PROG: begin
					stateNext.nvmProgEn = (stateReg.seq == SEQ_ARMED);
				end
				default: begin
					stateNext.seq = SEQ_IDLE;
				end
			endcase
		end
		// Soft reset also clears the sequence on the following cycle
		if (stateReg.softReset) begin
			stateNext.seq = SEQ_IDLE;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateReg <= '{SEQ_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, `CMD_REG_RESET};
		end else begin
			stateReg <= stateNext;
		end
	end

	assign regRdata    = stateReg.readData;
	assign ackSuppress = stateReg.ackSuppress;
	assign softReset   = stateReg.softReset;
	assign nvmReadEn   = stateReg.nvmReadEn;
	assign nvmProgEn   = stateReg.nvmProgEn;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	read_zero_a: assert property (@(posedge clk) disable iff (sys_rst) regRead |=> regRdata == 8'h00)
		else $error("command register read not zero");
	soft_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata == 8'hB6 |=> softReset && !nvmReadEn && !nvmProgEn)
		else $error("soft reset not raised");
	no_ack_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata == 8'hB6 && busIsI2c |=> ackSuppress)
		else $error("acknowledge not suppressed");
	read_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata == 8'h5D ##1 cmdWrite && regWdata == 8'hA5 |=> nvmReadEn)
		else $error("read enable missing after sequence");
	prog_seq_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata == 8'h5D ##1 (!cmdWrite)[*2] ##1 cmdWrite && regWdata == 8'hA0 |=> nvmProgEn)
		else $error("program enable missing after sequence");
	read_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		nvmReadEn |-> $past(regWdata) == 8'hA5 && $past(cmdWrite))
		else $error("read enable without command");
	abandon_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata != 8'h5D |=> stateReg.seq == SEQ_IDLE)
		else $error("sequence not abandoned");
	idle_code_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && regWdata == 8'h00 |=> !softReset && !nvmReadEn && !nvmProgEn && !ackSuppress)
		else $error("undefined code had an effect");

	// Read data never leaves zero, not only after a read strobe
	read_data_a: assert property (@(posedge clk) disable iff (sys_rst)
		regRdata == `CMD_READ_VALUE)
		else $error("read data left zero");

	// Soft reset is a single-cycle event for the configuration logic
	soft_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		softReset |=> !softReset)
		else $error("soft reset stood too long");

	// Soft reset only follows a soft-reset command write
	soft_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		softReset |-> $past(cmdWrite) && $past(regWdata) == `CMD_SOFT_RESET)
		else $error("soft reset without command");

	// A soft reset leaves no half-entered sequence behind
	reset_disarm_a: assert property (@(posedge clk) disable iff (sys_rst)
		softReset |=> stateReg.seq == SEQ_IDLE)
		else $error("sequence survived soft reset");

	// Acknowledge is only withheld for the soft-reset byte itself
	ack_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		ackSuppress |-> softReset)
		else $error("acknowledge withheld without soft reset");

	// Other serial modes keep their normal handshake
	ack_spi_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdIs(cmdWrite, regWdata, `CMD_SOFT_RESET) && !busIsI2c |=> !ackSuppress)
		else $error("acknowledge withheld off the two-wire bus");

	// The withheld acknowledge covers one byte only
	ack_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		ackSuppress |=> !ackSuppress)
		else $error("acknowledge withheld too long");

	// The arming code arms unless a soft reset is clearing the state
	arm_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdIs(cmdWrite, regWdata, `CMD_NVM_FIRST) && !stateReg.softReset |=> stateReg.seq == SEQ_ARMED)
		else $error("sequence not armed");

	// Idle cycles between the two steps keep the sequence armed
	arm_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg.seq == SEQ_ARMED && !cmdWrite && !stateReg.softReset |=> stateReg.seq == SEQ_ARMED)
		else $error("armed sequence lost while idle");

	// Read enable is one event per completed sequence
	read_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		nvmReadEn |=> !nvmReadEn)
		else $error("read enable stood too long");

	// Read and programming never open together
	enable_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(nvmReadEn && nvmProgEn))
		else $error("read and program enabled together");

	// Programming enable is one event per completed sequence
	prog_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		nvmProgEn |=> !nvmProgEn)
		else $error("program enable stood too long");

	// Programming enable only follows its closing code
	prog_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
		nvmProgEn |-> $past(cmdWrite) && $past(regWdata) == `CMD_NVM_PROG)
		else $error("program enable without command");

	// A closing code without the arming step opens nothing
	unarmed_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdIs(cmdWrite, regWdata, `CMD_NVM_READ) && stateReg.seq == SEQ_IDLE |=> !nvmReadEn)
		else $error("read enabled without arming");

	unarmed_prog_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdIs(cmdWrite, regWdata, `CMD_NVM_PROG) && stateReg.seq == SEQ_IDLE |=> !nvmProgEn)
		else $error("program enabled without arming");

	// A finished sequence must be entered again from the start
	closing_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && isClosingCode(regWdata) |=> stateReg.seq == SEQ_IDLE)
		else $error("sequence still armed after closing code");

	// Sequence state only ever holds its two legal codes
	seq_legal_a: assert property (@(posedge clk) disable iff (sys_rst)
		stateReg.seq inside {SEQ_IDLE, SEQ_ARMED})
		else $error("sequence state illegal");

	// Any code without a meaning raises no event at all
	undefined_code_a: assert property (@(posedge clk) disable iff (sys_rst)
		cmdWrite && !isDefinedCode(regWdata) |=> !softReset && !nvmReadEn && !nvmProgEn && !ackSuppress)
		else $error("undefined code raised an event");

	// Writes to other registers leave the sequence alone
	other_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		regWrite && regAddr != `CMD_REG_ADDR && !stateReg.softReset |=> $stable(stateReg.seq))
		else $error("other register write moved the sequence");
endmodule // sensor_command_register_decoder
`default_nettype wire

/* host_model.sv */
`default_nettype none
module host_model (
	input  wire logic       clk,
	output var  logic       regWrite,
	output var  logic       regRead,
	output var  logic       busIsI2c,
	output var  logic [7:0] regAddr,
	output var  logic [7:0] regWdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {regWrite, regRead, busIsI2c, regAddr, regWdata} = '0;
	// Strobe stays up, so two calls in a row give back-to-back command writes
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic i2c);
		@(negedge clk);
		{regWrite, regRead, busIsI2c, regAddr, regWdata} = {2'b10, i2c, a, d};
	endtask
	// Drop the strobe, n falling edges in all; data inverted so a stale byte never looks valid
	task automatic stop(input int n);
		@(negedge clk);
		{regWrite, regRead, regWdata} = {2'b01, ~regWdata}; // Missing ACK is not a failure
		repeat (n - 1) @(negedge clk);
	endtask
endmodule // host_model
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, sys_rst = 1'b1, regWrite, regRead, busIsI2c;
	logic       ackSuppress, softReset, nvmReadEn, nvmProgEn;
	logic [7:0] regAddr, regWdata, regRdata;
	int         bad_count = 0, cmp_count = 0;
	initial forever #2.5 clk = ~clk;
	host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .busIsI2c(busIsI2c),
		.regAddr(regAddr), .regWdata(regWdata));
	sensor_command_register_decoder dut (.clk(clk), .sys_rst(sys_rst), .regWrite(regWrite),
		.regRead(regRead), .busIsI2c(busIsI2c), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .ackSuppress(ackSuppress), .softReset(softReset),
		.nvmReadEn(nvmReadEn), .nvmProgEn(nvmProgEn));
	task automatic chk(input logic [11:0] exp);
		cmp_count++;
		if ({softReset, ackSuppress, nvmReadEn, nvmProgEn, regRdata} !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time,
				{softReset, ackSuppress, nvmReadEn, nvmProgEn, regRdata}, exp);
		end
	endtask
	// Two writes, then pulses and zero read data one cycle after the second
	task automatic pair(input logic [7:0] aAddr, input logic [7:0] a, input logic [7:0] b,
		input logic i2c, input logic [3:0] exp);
		host.wr(aAddr, a, 1'b0);
		host.wr(8'h7E, b, i2c);
		host.stop(1);
		chk({exp, 8'h00});
		$display("test %h %h done", a, b);
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog: the sequence needs well under 1 us
	initial begin
		#3000;
		bad_count++;
		close_out();
	end
	// Reset for four cycles, then command sequences
	initial begin
		#20 sys_rst = 1'b0;
		chk(12'h000);
		pair(8'h7E, 8'h5D, 8'hA5, 1'b0, 4'b0010);
		host.wr(8'h7E, 8'h5D, 1'b0);
		host.stop(3);
		host.wr(8'h7E, 8'hA0, 1'b0);
		host.stop(1);
		chk(12'h100);
		pair(8'h7E, 8'h5D, 8'hA0, 1'b1, 4'b0001);
		pair(8'h7E, 8'h5D, 8'hB6, 1'b1, 4'b1100);
		pair(8'h7E, 8'h00, 8'hB6, 1'b0, 4'b1000);
		host.wr(8'h7E, 8'h5D, 1'b0);
		pair(8'h7E, 8'h00, 8'hA5, 1'b0, 4'b0000);
		host.wr(8'h7E, 8'h5D, 1'b0);
		pair(8'h7E, 8'h33, 8'hA0, 1'b0, 4'b0000);
		host.wr(8'h7E, 8'h5D, 1'b0);
		pair(8'h7D, 8'hA5, 8'hA5, 1'b0, 4'b0010);
		pair(8'h7E, 8'hB6, 8'hA0, 1'b0, 4'b0000);
		pair(8'h7E, 8'h5D, 8'h5D, 1'b0, 4'b0000);
		close_out();
	end
endmodule // testbench
`default_nettype wire
